// ### core/qru_counter.sv
// Functional notes
// - B edge steps position, A level sets direction
// - revolution steps on index or position wrap
// - mode 00: no revolution, index/overflow clear position
// - mode 01: index steps revolution by direction flag
// - mode 01: index clears, overflow keeps counting up
// - opposing coincident position edge sets revolution direction
// - index, A, B together: use last flag
// - mode 10: overflow up, underflow down only
// - mode 10: overflow clears position, index ignored
// - mode 11: index by flag plus overflow/underflow
// - mode 11: index or overflow clears position
// - inversion request when flag and enable set
// - zero index, overflow, underflow sticky flags
// - position-revolution match request with enable
// - position match request with enable
// - both-match request with enable
// - out-of-range request with enable
// - overflow wraps to zero except in mode 01, underflow reloads maximum
`timescale 1ns/1ps
`default_nettype none

`include "qru_defs.svh"

module qru_counter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,

	// encoder inputs, synchronous to ref_clk
	input wire logic phaseAInput,
	input wire logic phaseBInput,
	input wire logic indexInput,

	// counting configuration
	input wire logic countRun,
	input wire logic [1:0] phaseBEdgeSelect,
	input wire logic [1:0] indexEdgeSelect,
	input wire logic indexFunctionSelect,
	input wire logic [1:0] gateLevelSelect,
	input wire logic [1:0] revolutionModeField,

	// limit and compare values
	input wire logic [`QRU_POS_W-1:0] maximumPositionValue,
	input wire logic [`QRU_POS_W-1:0] positionCompareValue,
	input wire logic [`QRU_REV_W-1:0] revolutionCompareValue,

	// request enables
	input wire logic countInversionEnable,
	input wire logic posRevMatchEnable,
	input wire logic positionMatchEnable,
	input wire logic bothMatchEnable,
	input wire logic outOfRangeEnable,

	// flag clears, one pulse per write of 0
	input wire logic countInversionClear,
	input wire logic zeroIndexClear,
	input wire logic overflowClear,
	input wire logic underflowClear,
	input wire logic posRevMatchClear,
	input wire logic positionMatchClear,
	input wire logic bothMatchClear,
	input wire logic outOfRangeClear,

	// counter values
	output logic [`QRU_POS_W-1:0] positionCountValue,
	output logic [`QRU_REV_W-1:0] revolutionCountValue,
	output logic positionDirectionFlag,

	// request flags
	output logic countInversionFlag,
	output logic zeroIndexFlag,
	output logic overflowFlag,
	output logic underflowFlag,
	output logic posRevMatchFlag,
	output logic positionMatchFlag,
	output logic bothMatchFlag,
	output logic outOfRangeFlag,

	// combined request
	output logic interruptRequest
);

	qru_pkg::qru_state_t st;
	qru_pkg::qru_state_t next_st;
	qru_pkg::qru_rev_mode_t revMode;

	// edge detector outputs
	logic phaseBEdge;
	logic phaseAEdge;
	logic indexEdge;

	// position counter events
	logic gateOpen;
	logic posEvent;
	logic posDown;
	logic atMax;
	logic atZero;
	logic overflowEvent;
	logic underflowEvent;

	// index events
	logic indexClearEdge;
	logic indexResetsPos;
	logic overflowResetsPos;
	logic revFromIndex;
	logic revFromWrap;
	logic indexDown;

	// flag events
	logic inversionEvent;
	logic rangeEvent;
	logic valueChanged;
	logic posMatchEvent;
	logic revMatchEvent;
	logic [`QRU_FLAG_N-1:0] flagSet;
	logic [`QRU_FLAG_N-1:0] flagClear;
	logic [`QRU_FLAG_N-1:0] flagEnable;
	logic [`QRU_FLAG_N-1:0] flags;

	// one step of the position counter with wrap and reload
	function automatic logic [`QRU_POS_W-1:0] posStep(
		input logic [`QRU_POS_W-1:0] pos,
		input logic [`QRU_POS_W-1:0] maxPos,
		input logic down,
		input logic wrapUp
	);
		logic [`QRU_POS_W-1:0] res;
		res = pos;
		if (down) begin
			if (pos == `QRU_POS_RST) begin
				res = maxPos;
			end else begin
				res = pos - `QRU_POS_W'(1);
			end
		end else begin
			if (wrapUp && pos == maxPos) begin
				res = `QRU_POS_RST;
			end else begin
				res = pos + `QRU_POS_W'(1);
			end
		end
		return res;
	endfunction

	// one step of the revolution counter, modulo its width
	function automatic logic [`QRU_REV_W-1:0] revStep(
		input logic [`QRU_REV_W-1:0] rev,
		input logic down
	);
		logic [`QRU_REV_W-1:0] res;
		res = down ? rev - `QRU_REV_W'(1) : rev + `QRU_REV_W'(1);
		return res;
	endfunction

	assign revMode = qru_pkg::qru_rev_mode_t'(revolutionModeField);

	qru_edge_detect phaseBDetect (
		.ref_clk(ref_clk),
		.rst(rst),
		.sigIn(phaseBInput),
		.edgeSelect(phaseBEdgeSelect),
		.activeEdge(phaseBEdge)
	);

	// any change of phase A, only needed to spot three-way coincidence
	qru_edge_detect phaseADetect (
		.ref_clk(ref_clk),
		.rst(rst),
		.sigIn(phaseAInput),
		.edgeSelect(`QRU_EDGE_BOTH),
		.activeEdge(phaseAEdge)
	);

	qru_edge_detect indexDetect (
		.ref_clk(ref_clk),
		.rst(rst),
		.sigIn(indexInput),
		.edgeSelect(indexEdgeSelect),
		.activeEdge(indexEdge)
	);

	// position counting: index as gate only lets counts through at its level
	always_comb begin
		if (!indexFunctionSelect) begin
			gateOpen = 1'b1;
		end else begin
			case (gateLevelSelect)
				`QRU_GATE_LOW: gateOpen = !indexInput;
				`QRU_GATE_HIGH: gateOpen = indexInput;
				default: gateOpen = 1'b0;
			endcase
		end
	end

	assign posEvent = countRun && gateOpen && phaseBEdge;
	assign posDown = !phaseAInput;
	assign atMax = st.position == maximumPositionValue;
	assign atZero = st.position == `QRU_POS_RST;
	assign overflowEvent = posEvent && !posDown && atMax;
	assign underflowEvent = posEvent && posDown && atZero;

	// index clear only exists when the index is not used as a gate
	assign indexClearEdge = indexEdge && !indexFunctionSelect;

	// which events clear the position, per revolution mode
	always_comb begin
		case (revMode)
			qru_pkg::QRU_REV_DISABLED: begin
				indexResetsPos = indexClearEdge;
				overflowResetsPos = 1'b1;
				revFromIndex = 1'b0;
				revFromWrap = 1'b0;
			end
			qru_pkg::QRU_REV_INDEX_ONLY: begin
				indexResetsPos = indexClearEdge;
				overflowResetsPos = 1'b0;
				revFromIndex = indexClearEdge;
				revFromWrap = 1'b0;
			end
			qru_pkg::QRU_REV_WRAP_ONLY: begin
				indexResetsPos = 1'b0;
				overflowResetsPos = 1'b1;
				revFromIndex = 1'b0;
				revFromWrap = overflowEvent || underflowEvent;
			end
			qru_pkg::QRU_REV_INDEX_AND_WRAP: begin
				indexResetsPos = indexClearEdge;
				overflowResetsPos = 1'b1;
				revFromIndex = indexClearEdge;
				revFromWrap = overflowEvent || underflowEvent;
			end
			default: begin
				indexResetsPos = 1'b0;
				overflowResetsPos = 1'b1;
				revFromIndex = 1'b0;
				revFromWrap = 1'b0;
			end
		endcase
	end

	// a coincident position count decides the index direction, unless
	// phase A moved too: then the stored flag is the only safe reference
	always_comb begin
		if (posEvent && !phaseAEdge) begin
			indexDown = posDown;
		end else begin
			indexDown = st.dirFlag;
		end
	end

	always_comb begin
		next_st = st;
		if (posEvent) begin
			next_st.position = posStep(st.position, maximumPositionValue, posDown, overflowResetsPos);
			next_st.dirFlag = posDown;
		end
		// index clear wins over a coincident count
		if (indexResetsPos) begin
			next_st.position = `QRU_POS_RST;
		end
		if (revFromIndex) begin
			next_st.revolution = revStep(st.revolution, indexDown);
		end else if (revFromWrap) begin
			next_st.revolution = revStep(st.revolution, underflowEvent);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '{position: `QRU_POS_RST, revolution: `QRU_REV_RST, dirFlag: `QRU_DIR_RST};
		end else begin
			st <= next_st;
		end
	end

	// flag events
	assign inversionEvent = posEvent && (posDown != st.dirFlag);
	// only the index-only mode can carry the count past the maximum
	assign rangeEvent = posEvent && !posDown && (next_st.position > maximumPositionValue);
	assign valueChanged = (next_st.position != st.position) || (next_st.revolution != st.revolution);
	// compare on update only, so a held match does not re-arm after a clear
	assign posMatchEvent = valueChanged && (next_st.position == positionCompareValue);
	assign revMatchEvent = valueChanged && (next_st.revolution == revolutionCompareValue);

	always_comb begin
		flagSet = '0;
		flagSet[`QRU_FLG_INV] = inversionEvent;
		// wrap-only mode ignores the index entirely, flag included
		flagSet[`QRU_FLG_ZERO] = indexClearEdge && (revMode != qru_pkg::QRU_REV_WRAP_ONLY);
		flagSet[`QRU_FLG_OVF] = overflowEvent;
		flagSet[`QRU_FLG_UNF] = underflowEvent;
		flagSet[`QRU_FLG_REVM] = revMatchEvent;
		flagSet[`QRU_FLG_POSM] = posMatchEvent;
		flagSet[`QRU_FLG_BOTHM] = posMatchEvent && revMatchEvent;
		flagSet[`QRU_FLG_RANGE] = rangeEvent;
	end

	always_comb begin
		flagClear = '0;
		flagClear[`QRU_FLG_INV] = countInversionClear;
		flagClear[`QRU_FLG_ZERO] = zeroIndexClear;
		flagClear[`QRU_FLG_OVF] = overflowClear;
		flagClear[`QRU_FLG_UNF] = underflowClear;
		flagClear[`QRU_FLG_REVM] = posRevMatchClear;
		flagClear[`QRU_FLG_POSM] = positionMatchClear;
		flagClear[`QRU_FLG_BOTHM] = bothMatchClear;
		flagClear[`QRU_FLG_RANGE] = outOfRangeClear;
	end

	// zero index, overflow and underflow have no enable of their own
	always_comb begin
		flagEnable = '0;
		flagEnable[`QRU_FLG_INV] = countInversionEnable;
		flagEnable[`QRU_FLG_ZERO] = 1'b1;
		flagEnable[`QRU_FLG_OVF] = 1'b1;
		flagEnable[`QRU_FLG_UNF] = 1'b1;
		flagEnable[`QRU_FLG_REVM] = posRevMatchEnable;
		flagEnable[`QRU_FLG_POSM] = positionMatchEnable;
		flagEnable[`QRU_FLG_BOTHM] = bothMatchEnable;
		flagEnable[`QRU_FLG_RANGE] = outOfRangeEnable;
	end

	qru_irq_flags #(
		.N(`QRU_FLAG_N)
	) requestFlags (
		.ref_clk(ref_clk),
		.rst(rst),
		.flagSet(flagSet),
		.flagClear(flagClear),
		.flagEnable(flagEnable),
		.flags(flags),
		.interruptRequest(interruptRequest)
	);

	assign positionCountValue = st.position;
	assign revolutionCountValue = st.revolution;
	assign positionDirectionFlag = st.dirFlag;

	assign countInversionFlag = flags[`QRU_FLG_INV];
	assign zeroIndexFlag = flags[`QRU_FLG_ZERO];
	assign overflowFlag = flags[`QRU_FLG_OVF];
	assign underflowFlag = flags[`QRU_FLG_UNF];
	assign posRevMatchFlag = flags[`QRU_FLG_REVM];
	assign positionMatchFlag = flags[`QRU_FLG_POSM];
	assign bothMatchFlag = flags[`QRU_FLG_BOTHM];
	assign outOfRangeFlag = flags[`QRU_FLG_RANGE];

endmodule

`default_nettype wire

// ### core/qru_defs.svh
`ifndef QRU_DEFS_SVH
`define QRU_DEFS_SVH

// counter widths
`define QRU_POS_W 16
`define QRU_REV_W 16

// edge select codes for phase B and index inputs
`define QRU_EDGE_NONE 2'h0
`define QRU_EDGE_FALL 2'h1
`define QRU_EDGE_RISE 2'h2
`define QRU_EDGE_BOTH 2'h3

// revolution counter mode field codes
`define QRU_REV_DISABLED 2'h0
`define QRU_REV_INDEX_ONLY 2'h1
`define QRU_REV_WRAP_ONLY 2'h2
`define QRU_REV_INDEX_AND_WRAP 2'h3

// index gate level select codes (index used as gate)
`define QRU_GATE_LOW 2'h1
`define QRU_GATE_HIGH 2'h2

// positions of the request flags in the flag vector
`define QRU_FLAG_N 8
`define QRU_FLG_INV 0
`define QRU_FLG_ZERO 1
`define QRU_FLG_OVF 2
`define QRU_FLG_UNF 3
`define QRU_FLG_REVM 4
`define QRU_FLG_POSM 5
`define QRU_FLG_BOTHM 6
`define QRU_FLG_RANGE 7

// reset values
`define QRU_POS_RST 16'h0000
`define QRU_REV_RST 16'h0000
`define QRU_DIR_RST 1'h0

`endif

// ### core/qru_pkg.sv
`default_nettype none

`include "qru_defs.svh"

package qru_pkg;

	typedef enum logic [1:0] {
		QRU_REV_DISABLED = `QRU_REV_DISABLED,
		QRU_REV_INDEX_ONLY = `QRU_REV_INDEX_ONLY,
		QRU_REV_WRAP_ONLY = `QRU_REV_WRAP_ONLY,
		QRU_REV_INDEX_AND_WRAP = `QRU_REV_INDEX_AND_WRAP
	} qru_rev_mode_t;

	typedef struct packed {
		logic [`QRU_POS_W-1:0] position;
		logic [`QRU_REV_W-1:0] revolution;
		logic dirFlag;
	} qru_state_t;

endpackage

`default_nettype wire

// ### core/qru_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

`include "qru_defs.svh"

module qru_edge_detect (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sampled input and edge choice
	input wire logic sigIn,
	input wire logic [1:0] edgeSelect,
	// detected active edge, one cycle
	output logic activeEdge
);

	typedef struct packed {
		logic prev;
	} qru_edge_state_t;

	qru_edge_state_t st;
	qru_edge_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.prev = sigIn;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// edge pulse is combinational so it lines up with the counter update
	always_comb begin
		case (edgeSelect)
			`QRU_EDGE_FALL: activeEdge = st.prev && !sigIn;
			`QRU_EDGE_RISE: activeEdge = !st.prev && sigIn;
			`QRU_EDGE_BOTH: activeEdge = st.prev ^ sigIn;
			default: activeEdge = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ### core/qru_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none

module qru_irq_flags #(
	parameter int N = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// hardware events and software clears
	input wire logic [N-1:0] flagSet,
	input wire logic [N-1:0] flagClear,
	input wire logic [N-1:0] flagEnable,
	// sticky flags and request
	output logic [N-1:0] flags,
	output logic interruptRequest
);

	typedef struct packed {
		logic [N-1:0] flags;
		logic irq;
	} qru_flag_state_t;

	qru_flag_state_t st;
	qru_flag_state_t next_st;

	always_comb begin
		next_st = st;
		// set beats a clear arriving in the same cycle
		next_st.flags = (st.flags & ~flagClear) | flagSet;
		next_st.irq = |(st.flags & flagEnable);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flags = st.flags;
	assign interruptRequest = st.irq;

endmodule

`default_nettype wire

// ### bench/qru_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none

module qru_encoder_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// step and index requests
	input wire logic stepReq,
	input wire logic stepDir,
	input wire logic idxReq,
	// encoder lines, low in reset so no false edge at release
	output logic phaseA,
	output logic phaseB,
	output logic index
);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phaseA <= 1'b0;
			phaseB <= 1'b0;
			index <= 1'b0;
		end else begin
			if (stepReq) begin
				phaseA <= stepDir;
				phaseB <= ~phaseB;
			end
			if (idxReq)
				index <= ~index;
		end
	end
endmodule

`default_nettype wire

// ### bench/qru_counter_monitor.sv
`timescale 1ns/1ps
`default_nettype none

`include "qru_defs.svh"

module qru_counter_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// configuration
	input wire logic [1:0] revolutionModeField,
	input wire logic [`QRU_POS_W-1:0] maximumPositionValue,
	input wire logic countInversionEnable,
	input wire logic posRevMatchEnable,
	input wire logic positionMatchEnable,
	input wire logic bothMatchEnable,
	input wire logic outOfRangeEnable,
	input wire logic overflowClear,
	// counters
	input wire logic [`QRU_POS_W-1:0] positionCountValue,
	input wire logic [`QRU_REV_W-1:0] revolutionCountValue,
	input wire logic positionDirectionFlag,
	// flags and request
	input wire logic countInversionFlag,
	input wire logic zeroIndexFlag,
	input wire logic overflowFlag,
	input wire logic underflowFlag,
	input wire logic posRevMatchFlag,
	input wire logic positionMatchFlag,
	input wire logic bothMatchFlag,
	input wire logic outOfRangeFlag,
	input wire logic interruptRequest
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	wire logic [`QRU_POS_W-1:0] pos = positionCountValue;
	wire logic [`QRU_POS_W-1:0] mx = maximumPositionValue;
	wire logic [`QRU_REV_W-1:0] rev = revolutionCountValue;
	// zero index, overflow, underflow have no enable
	wire logic pend = zeroIndexFlag || overflowFlag || underflowFlag || countInversionFlag && countInversionEnable
		|| posRevMatchFlag && posRevMatchEnable || positionMatchFlag && positionMatchEnable
		|| bothMatchFlag && bothMatchEnable || outOfRangeFlag && outOfRangeEnable;

	a_irq_or: assert property (interruptRequest == $past(pend)) else
		$error("request not or of enabled flags");
	a_ovf_sticky: assert property (overflowFlag && !overflowClear |=> overflowFlag) else
		$error("overflow flag lost");
	a_wrap_up: assert property (revolutionModeField == 2'h2 && $past(pos) == mx && pos == 16'h0 |->
		rev == $past(rev) + 16'h1 && overflowFlag) else $error("bad overflow wrap");
	a_wrap_down: assert property (revolutionModeField == 2'h2 && $past(pos) == 16'h0 && pos == mx |->
		rev == $past(rev) - 16'h1 && underflowFlag) else $error("bad underflow reload");
	a_past_max: assert property (revolutionModeField == 2'h1 && $past(pos) == mx && pos == mx + 16'h1 |->
		$stable(rev) && overflowFlag && outOfRangeFlag) else $error("bad count past maximum");
	a_rev_off: assert property (revolutionModeField == 2'h0 |-> $stable(rev)) else
		$error("revolution moved while disabled");
	a_dir_up: assert property (pos == $past(pos) + 16'h1 |-> !positionDirectionFlag) else
		$error("direction flag wrong on up");
	a_dir_down: assert property (revolutionModeField == 2'h2 && pos == $past(pos) - 16'h1 |->
		positionDirectionFlag) else $error("direction flag wrong on down");
	a_index_ignored: assert property (revolutionModeField == 2'h2 && !$past(zeroIndexFlag) |->
		!zeroIndexFlag) else $error("index seen while ignored");
endmodule

bind qru_counter qru_counter_monitor i_qru_counter_monitor (.ref_clk, .rst, .revolutionModeField,
	.maximumPositionValue, .countInversionEnable, .posRevMatchEnable, .positionMatchEnable, .bothMatchEnable,
	.outOfRangeEnable, .overflowClear, .positionCountValue, .revolutionCountValue, .positionDirectionFlag,
	.countInversionFlag, .zeroIndexFlag, .overflowFlag, .underflowFlag, .posRevMatchFlag, .positionMatchFlag,
	.bothMatchFlag, .outOfRangeFlag, .interruptRequest);

`default_nettype wire

// ### bench/test_qru_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "qru_defs.svh"

module test_qru_counter;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic stepReq = 1'b0, stepDir = 1'b0, idxReq = 1'b0, countRun = 1'b0;
	logic phaseA, phaseB, index, dirFlag, irq;
	logic [1:0] md = 2'h0, bs = 2'h3, zs = 2'h3;
	logic [4:0] en = 5'h00;
	logic [7:0] clr = 8'h00, fl;
	logic [15:0] mx = 16'h9, pc = 16'h1, rc = 16'h1, pos, rev, ep, er;
	logic [32:0] seen, last;
	logic [32:0] q[$];
	bit df, bl, zl, al, rq;
	int failures = 0;
	int check_count = 0;

	always #50 ref_clk = ~ref_clk;

	qru_encoder_model i_qru_encoder_model (.ref_clk, .rst, .stepReq, .stepDir, .idxReq, .phaseA, .phaseB, .index);

	qru_counter i_qru_counter (.ref_clk, .rst, .phaseAInput(phaseA), .phaseBInput(phaseB), .indexInput(index),
		.countRun, .phaseBEdgeSelect(bs), .indexEdgeSelect(zs), .indexFunctionSelect(1'b0),
		.gateLevelSelect(2'h0), .revolutionModeField(md), .maximumPositionValue(mx),
		.positionCompareValue(pc), .revolutionCompareValue(rc),
		.countInversionEnable(en[0]), .posRevMatchEnable(en[1]), .positionMatchEnable(en[2]),
		.bothMatchEnable(en[3]), .outOfRangeEnable(en[4]),
		.countInversionClear(clr[0]), .zeroIndexClear(clr[1]), .overflowClear(clr[2]), .underflowClear(clr[3]),
		.posRevMatchClear(clr[4]), .positionMatchClear(clr[5]), .bothMatchClear(clr[6]), .outOfRangeClear(clr[7]),
		.positionCountValue(pos), .revolutionCountValue(rev), .positionDirectionFlag(dirFlag),
		.countInversionFlag(fl[0]), .zeroIndexFlag(fl[1]), .overflowFlag(fl[2]), .underflowFlag(fl[3]),
		.posRevMatchFlag(fl[4]), .positionMatchFlag(fl[5]), .bothMatchFlag(fl[6]), .outOfRangeFlag(fl[7]),
		.interruptRequest(irq));

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic rst_dut();
		@(posedge ref_clk);
		rst <= 1'b1;
		stepReq <= 1'b0;
		idxReq <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		{df, bl, zl, al, rq, ep, er} = '0;
		seen = '0;
		last = '0;
		q.delete();
		#1 chk({dirFlag, rev, pos}, 33'h0);
	endtask

	// s step, d up, z index toggle, run count enable; the count lands two edges later
	task automatic act(input bit s, input bit d, input bit z, input bit run);
		bit cnt, zi, dn, wu, wd;
		@(posedge ref_clk);
		stepReq <= s;
		stepDir <= d;
		idxReq <= z;
		countRun <= rq;
		rq = run;
		bl ^= s;
		zl ^= z;
		cnt = s && run && (bs[1] && bl || bs[0] && !bl);
		zi = z && md != 2'h2 && (zs[1] && zl || zs[0] && !zl);
		dn = (cnt && d == al) ? !d : df;
		al = s ? d : al;
		wu = cnt && d && ep == mx && md != 2'h1;
		wd = cnt && !d && ep == 16'h0;
		if (cnt)
			ep = wu ? 16'h0 : wd ? mx : d ? ep + 16'h1 : ep - 16'h1;
		if (cnt)
			df = !d;
		if (zi)
			ep = 16'h0;
		if (zi && md[0])
			er = dn ? er - 16'h1 : er + 16'h1;
		else if (md[1])
			er = er + wu - wd;
		if ({df, er, ep} !== last) begin
			last = {df, er, ep};
			q.push_back(last);
		end
	endtask

	always @(posedge ref_clk) begin
		#1;
		if (!rst && {dirFlag, rev, pos} !== seen) begin
			seen = {dirFlag, rev, pos};
			chk(seen, q.size() ? q.pop_front() : ~seen);
		end
	end

	initial begin
		void'($urandom(8));
		for (int m = 0; m < 4; m++) begin
			@(posedge ref_clk);
			md <= 2'(m);
			mx <= 16'(2 + $urandom % 9);
			bs <= 2'(1 + $urandom % 3);
			zs <= 2'(1 + $urandom % 3);
			pc <= 16'($urandom % 8);
			rc <= 16'($urandom % 3);
			rst_dut();
			repeat (300) begin
				act($urandom % 2, $urandom % 2, $urandom % 4 == 0, $urandom % 8 != 0);
				en <= 5'($urandom);
				clr <= ($urandom % 16 == 0) ? 8'($urandom) : 8'h00;
			end
			repeat (3) act(0, 0, 0, 1);
			chk(q.size(), 0);
		end
		@(posedge ref_clk);
		md <= 2'h2;
		mx <= 16'h2;
		bs <= 2'h3;
		zs <= 2'h3;
		pc <= 16'h1;
		rc <= 16'h1;
		en <= 5'h00;
		clr <= 8'h00;
		rst_dut();
		repeat (3) act(1, 1, 0, 1);
		repeat (4) act(0, 0, 0, 1);
		#1;
		chk(fl, 8'h34);
		chk(irq, 1'b1);
		act(0, 0, 0, 1);
		clr <= 8'h04;
		act(0, 0, 0, 1);
		clr <= 8'h00;
		repeat (2) act(0, 0, 0, 1);
		#1;
		chk(fl, 8'h30);
		chk(irq, 1'b0);
		act(0, 0, 0, 1);
		en <= 5'h04;
		repeat (2) act(0, 0, 0, 1);
		#1;
		chk(irq, 1'b1);
		// two down steps from zero: underflow, inversion, then both matches
		act(0, 0, 0, 1);
		rc <= 16'h0;
		clr <= 8'hff;
		act(0, 0, 0, 1);
		clr <= 8'h00;
		repeat (2) act(1, 0, 0, 1);
		// index in wrap-only mode must leave everything alone
		act(0, 0, 1, 1);
		repeat (2) act(0, 0, 0, 1);
		#1;
		chk(fl, 8'h79);
		md <= 2'h3;
		act(0, 0, 1, 1);
		repeat (3) act(0, 0, 0, 1);
		#1;
		chk(fl, 8'h7b);
		chk(q.size(), 0);
		report_and_stop();
	end
endmodule

`default_nettype wire
